// ==== rtl/pbm_regs.sv ====
// packet buffer page manager: command, pointer and window registers
`timescale 1ns/1ps
`include "pbm_defs.svh"
module pbm_regs #(
  parameter int TX_DEPTH = 5,
  parameter int RX_DEPTH = 16,
  parameter int EPS = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata_r,
  input wire logic rx_allocation_done_irq_req,
  input wire logic [3:0] rx_allocation_done_irq_pages,
  output logic rx_grant_r,
  output pbm_pkg::pbm_pkt_t rx_grant_pkt_r,
  input wire logic rx_push,
  input wire pbm_pkg::pbm_pkt_t rx_push_pkt,
  input wire logic rx_release,
  input wire pbm_pkg::pbm_pkt_t rx_release_pkt,
  output logic rx_nak_r,
  output logic rx_queue_empty_r,
  output logic allocation_done_irq_r,
  input wire logic [3:0] tx_ep,
  input wire logic tx_pop,
  output pbm_pkg::pbm_pkt_t tx_head_pkt_r,
  output logic tx_head_valid_r
);
  import pbm_pkg::*;

  localparam int PAGES = `PBM_PAGES;
  localparam int RXW = $clog2(RX_DEPTH);
  localparam int TXW = $clog2(TX_DEPTH + 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] ptr_low_wr_r;
  logic [10:0] ptr_r;
  logic [10:0] used_addr_r;
  logic rx_queue_window_select_r;
  logic pointer_step_enable_r;
  logic read_dir_r;
  logic [3:0] tx_sel_r;
  pbm_pkt_t pnr_r;
  logic receive_hold_r;
  logic failed_r;
  pbm_pkt_t arr_pkt_r;
  logic [PAGES-1:0] used_r;
  pbm_pkt_t owner_r [PAGES];
  logic [3:0] pidx_r [PAGES];
  logic [7:0] mem [PAGES*`PBM_PAGE_BYTES];
  logic [7:0] pf_r;
  pbm_pkt_t rxq [RX_DEPTH];
  logic [RXW-1:0] rxq_rd_r;
  logic [RXW-1:0] rxq_wr_r;
  logic [RXW:0] rxq_cnt_r;
  pbm_pkt_t txq [EPS][TX_DEPTH];
  logic [TXW-1:0] txq_cnt_r [EPS];
  logic [TXW-1:0] txc_nxt [EPS];
  pbm_state_e state_r;
  logic [3:0] allocation_done_irq_left_r;
  logic [3:0] allocation_done_irq_idx_r;
  pbm_pkt_t allocation_done_irq_pkt_r;
  logic allocation_done_irq_rx_r;
  logic [5:0] free_page_count_r;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [5:0] lowest_free(input logic [PAGES-1:0] u);
    logic [5:0] r;
    r = 6'h00;
    for (int i = PAGES - 1; i >= 0; i--) begin
      if (!u[i]) begin
        r = {1'h1, 5'(i)};
      end
    end
    return r;
  endfunction : lowest_free

  function automatic logic [PAGES-1:0] owned_mask(
    input logic [PAGES-1:0] u,
    input pbm_pkt_t own [PAGES],
    input pbm_pkt_t pkt
  );
    logic [PAGES-1:0] m;
    m = '0;
    for (int i = 0; i < PAGES; i++) begin
      m[i] = u[i] && (own[i] == pkt);
    end
    return m;
  endfunction : owned_mask

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire wr_plow = cpu_wr && (cpu_addr == `PBM_ADDR_PLOW);
  wire wr_phigh = cpu_wr && (cpu_addr == `PBM_ADDR_PHIGH);
  wire wr_txsel = cpu_wr && (cpu_addr == `PBM_ADDR_TXSEL);
  wire wr_pnr = cpu_wr && (cpu_addr == `PBM_ADDR_PNR);
  wire wr_free = cpu_wr && (cpu_addr == `PBM_ADDR_FREE);
  wire cmd_go = cpu_wr && (cpu_addr == `PBM_ADDR_CMD);
  wire [2:0] command_opcode = cpu_wdata[7:5];
  wire [3:0] cmd_count = cpu_wdata[3:0];
  wire count_ok = cmd_count <= `PBM_MAX_COUNT;
  wire mmu_reset = cmd_go && (command_opcode == `PBM_OP_RESET);
  wire rx_nonempty = rxq_cnt_r != '0;
  wire pbm_pkt_t rx_head = rxq[rxq_rd_r];
  wire rx_pop = cmd_go && rx_nonempty &&
    ((command_opcode == `PBM_OP_POP) ||
     (command_opcode == `PBM_OP_POP_REL));
  wire rx_in = rx_push && (rxq_cnt_r != (RXW+1)'(RX_DEPTH));
  wire fw_allocation_done_irq = cmd_go && (command_opcode == `PBM_OP_ALLOCATION_DONE_IRQ) && count_ok &&
    (state_r == PBM_IDLE);
  wire rx_start = (state_r == PBM_IDLE) && !cmd_go && rx_allocation_done_irq_req &&
    !receive_hold_r && (rx_allocation_done_irq_pages <= `PBM_MAX_COUNT);
  wire tx_enq = cmd_go && (command_opcode == `PBM_OP_ENQ) &&
    (txq_cnt_r[tx_sel_r] < TXW'(TX_DEPTH));
  wire tx_clr = cmd_go && (command_opcode == `PBM_OP_TXRST);
  wire tx_out = tx_pop && (txq_cnt_r[tx_ep] != '0);

  // window addressing
  wire pbm_pkt_t win_pkt = rx_queue_window_select_r ? rx_head : pnr_r;
  wire win_acc = (cpu_wr || cpu_rd) && (cpu_addr == `PBM_ADDR_WINDOW);
  logic [4:0] win_page;
  logic win_hit;
  always_comb begin
    win_page = 5'h00;
    win_hit = 1'h0;
    for (int i = 0; i < PAGES; i++) begin
      if (used_r[i] && owner_r[i] == win_pkt && pidx_r[i] == ptr_r[10:7]) begin
        win_page = 5'(i);
        win_hit = 1'h1;
      end
    end
  end
  wire [11:0] ram_addr = {win_page, ptr_r[6:0]};
  wire win_go = win_acc && win_hit;
  wire win_wr = win_go && cpu_wr && !read_dir_r;

  // page allocation and release
  wire [5:0] lf = lowest_free(used_r);
  wire take = (state_r == PBM_ALLOCATION_DONE_IRQ) && lf[5];
  wire [4:0] take_page = lf[4:0];
  wire pbm_pkt_t take_pkt = (allocation_done_irq_idx_r == 4'h0) ? take_page : allocation_done_irq_pkt_r;
  wire allocation_done_irq_last = take && (allocation_done_irq_left_r == 4'h0);
  wire [PAGES-1:0] set_mask = take ? ({{(PAGES-1){1'h0}}, 1'h1} << take_page)
    : '0;
  // page map passed in so the masks follow every change of the map
  wire [PAGES-1:0] rel_pkt_mask = owned_mask(used_r, owner_r, pnr_r);
  wire [PAGES-1:0] rel_head_mask = owned_mask(used_r, owner_r, rx_head);
  wire [PAGES-1:0] rel_rx_mask = owned_mask(used_r, owner_r, rx_release_pkt);
  wire [PAGES-1:0] rel_mask =
    ((cmd_go && command_opcode == `PBM_OP_REL_PKT) ? rel_pkt_mask : '0) |
    ((rx_pop && command_opcode == `PBM_OP_POP_REL) ? rel_head_mask : '0) |
    (rx_release ? rel_rx_mask : '0);
  wire [PAGES-1:0] used_nxt = mmu_reset ? '0 :
    ((used_r & ~rel_mask) | set_mask);
  logic [5:0] free_nxt;
  always_comb begin
    free_nxt = 6'h00;
    for (int i = 0; i < PAGES; i++) begin
      free_nxt = free_nxt + 6'(!used_nxt[i]);
    end
  end

  // endpoint queue counts
  always_comb begin
    for (int e = 0; e < EPS; e++) begin
      txc_nxt[e] = txq_cnt_r[e] + TXW'(tx_enq && tx_sel_r == 4'(e))
        - TXW'(tx_out && tx_ep == 4'(e));
      if (mmu_reset || (tx_clr && tx_sel_r == 4'(e))) begin
        txc_nxt[e] = '0;
      end
    end
  end
  wire [TXW-1:0] enq_slot = txq_cnt_r[tx_sel_r] -
    TXW'(tx_out && tx_ep == tx_sel_r);

  // read-back
  logic [7:0] rd_mux;
  always_comb begin
    unique case (cpu_addr)
      `PBM_ADDR_WINDOW: rd_mux = pf_r;
      `PBM_ADDR_PLOW: rd_mux = used_addr_r[7:0];
      `PBM_ADDR_PHIGH: rd_mux = {rx_queue_window_select_r,
        pointer_step_enable_r, read_dir_r, 2'h0, ptr_r[10:8]};
      `PBM_ADDR_TXSEL: rd_mux = {4'h0, tx_sel_r};
      `PBM_ADDR_ARR: rd_mux = {failed_r, 2'h0, arr_pkt_r};
      `PBM_ADDR_PNR: rd_mux = {3'h0, pnr_r};
      `PBM_ADDR_FREE: rd_mux = {receive_hold_r, 1'h0, free_page_count_r};
      default: rd_mux = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ptr_low_wr_r <= 8'h00;
      ptr_r <= 11'h000;
      used_addr_r <= 11'h000;
      rx_queue_window_select_r <= 1'h0;
      pointer_step_enable_r <= 1'h0;
      read_dir_r <= 1'h0;
      tx_sel_r <= 4'h0;
      pnr_r <= 5'h00;
      receive_hold_r <= 1'h0;
      cpu_rdata_r <= 8'h00;
    end else begin
      cpu_rdata_r <= cpu_rd ? rd_mux : 8'h00;
      if (wr_plow) ptr_low_wr_r <= cpu_wdata;
      if (wr_phigh) begin
        ptr_r <= {cpu_wdata[2:0], ptr_low_wr_r};
        rx_queue_window_select_r <= cpu_wdata[`PBM_BIT_RCV];
        pointer_step_enable_r <= cpu_wdata[`PBM_BIT_STEP];
        read_dir_r <= cpu_wdata[`PBM_BIT_READ];
      end else if (win_acc && pointer_step_enable_r) begin
        ptr_r <= ptr_r + 11'h001;
      end
      if (win_go) used_addr_r <= ptr_r;
      if (wr_txsel) tx_sel_r <= cpu_wdata[3:0];
      if (wr_pnr) pnr_r <= cpu_wdata[4:0];
      if (wr_free) receive_hold_r <= cpu_wdata[`PBM_BIT_HOLD];
    end
  end

  // prefetch runs every cycle so read data is ready as soon as read is set
  always_ff @(posedge core_clk) begin
    if (win_wr) mem[ram_addr] <= cpu_wdata;
    pf_r <= mem[ram_addr];
    if (take) begin
      owner_r[take_page] <= take_pkt;
      pidx_r[take_page] <= allocation_done_irq_idx_r;
    end
    if (rx_in) rxq[rxq_wr_r] <= rx_push_pkt;
    for (int e = 0; e < EPS; e++) begin
      for (int k = 0; k < TX_DEPTH - 1; k++) begin
        if (tx_out && tx_ep == 4'(e)) txq[e][k] <= txq[e][k+1];
      end
    end
    if (tx_enq) txq[tx_sel_r][enq_slot] <= pnr_r;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= PBM_IDLE;
      used_r <= '0;
      free_page_count_r <= `PBM_FREE_RESET;
      allocation_done_irq_left_r <= 4'h0;
      allocation_done_irq_idx_r <= 4'h0;
      allocation_done_irq_pkt_r <= 5'h00;
      allocation_done_irq_rx_r <= 1'h0;
      failed_r <= 1'h0;
      arr_pkt_r <= 5'h00;
      allocation_done_irq_r <= 1'h0;
      rx_grant_r <= 1'h0;
      rx_grant_pkt_r <= 5'h00;
    end else begin
      used_r <= used_nxt;
      free_page_count_r <= free_nxt;
      allocation_done_irq_r <= allocation_done_irq_last && !allocation_done_irq_rx_r && !mmu_reset;
      rx_grant_r <= allocation_done_irq_last && allocation_done_irq_rx_r && !mmu_reset;
      if (allocation_done_irq_last) rx_grant_pkt_r <= take_pkt;
      if (take) begin
        allocation_done_irq_left_r <= allocation_done_irq_left_r - 4'h1;
        allocation_done_irq_idx_r <= allocation_done_irq_idx_r + 4'h1;
        allocation_done_irq_pkt_r <= take_pkt;
      end
      unique case (state_r)
        PBM_IDLE: begin
          if (fw_allocation_done_irq || rx_start) begin
            state_r <= PBM_ALLOCATION_DONE_IRQ;
            allocation_done_irq_left_r <= fw_allocation_done_irq ? cmd_count : rx_allocation_done_irq_pages;
            allocation_done_irq_idx_r <= 4'h0;
            allocation_done_irq_rx_r <= !fw_allocation_done_irq;
          end
          if (fw_allocation_done_irq) failed_r <= 1'h1;
        end
        PBM_ALLOCATION_DONE_IRQ: begin
          // a pending request waits here until a release frees a page
          if (allocation_done_irq_last) begin
            state_r <= PBM_IDLE;
            if (!allocation_done_irq_rx_r) begin
              failed_r <= 1'h0;
              arr_pkt_r <= take_pkt;
            end
          end
        end
      endcase
      if (mmu_reset) begin
        state_r <= PBM_IDLE;
        failed_r <= 1'h0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxq_rd_r <= '0;
      rxq_wr_r <= '0;
      rxq_cnt_r <= '0;
      rx_nak_r <= 1'h0;
      rx_queue_empty_r <= 1'h1;
      tx_head_pkt_r <= 5'h00;
      tx_head_valid_r <= 1'h0;
      for (int e = 0; e < EPS; e++) txq_cnt_r[e] <= '0;
    end else begin
      rx_nak_r <= receive_hold_r;
      rx_queue_empty_r <= !rx_nonempty;
      tx_head_pkt_r <= txq[tx_ep][0];
      tx_head_valid_r <= txq_cnt_r[tx_ep] != '0;
      for (int e = 0; e < EPS; e++) txq_cnt_r[e] <= txc_nxt[e];
      if (mmu_reset) begin
        rxq_rd_r <= '0;
        rxq_wr_r <= '0;
        rxq_cnt_r <= '0;
      end else begin
        if (rx_pop) rxq_rd_r <= rxq_rd_r + RXW'(1);
        if (rx_in) rxq_wr_r <= rxq_wr_r + RXW'(1);
        rxq_cnt_r <= rxq_cnt_r + (RXW+1)'(rx_in) - (RXW+1)'(rx_pop);
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_ptr_load;
    @(posedge core_clk) disable iff (rst)
    wr_phigh |=> ptr_r == {$past(cpu_wdata[2:0]), $past(ptr_low_wr_r)};
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer not loaded from high and low bytes");

  property p_used_addr;
    @(posedge core_clk) disable iff (rst)
    win_go |=> used_addr_r == $past(ptr_r);
  endproperty
  a_used_addr: assert property (p_used_addr)
    else $error("low pointer readback is not last used address");

  property p_step;
    @(posedge core_clk) disable iff (rst)
    (win_acc && pointer_step_enable_r) |=> ptr_r == $past(ptr_r) + 11'h001;
  endproperty
  a_step: assert property (p_step)
    else $error("pointer did not step after window access");

  property p_fail_set;
    @(posedge core_clk) disable iff (rst)
    fw_allocation_done_irq && !mmu_reset |=> failed_r && state_r == PBM_ALLOCATION_DONE_IRQ;
  endproperty
  a_fail_set: assert property (p_fail_set)
    else $error("failed flag not set on allocate");

  property p_pending;
    @(posedge core_clk) disable iff (rst)
    (state_r == PBM_ALLOCATION_DONE_IRQ && (&used_r) && !mmu_reset) |=>
      state_r == PBM_ALLOCATION_DONE_IRQ;
  endproperty
  a_pending: assert property (p_pending)
    else $error("allocation left pending state with no free page");

  property p_reset_cmd;
    @(posedge core_clk) disable iff (rst)
    mmu_reset |=> used_r == '0 && rxq_cnt_r == '0 && !failed_r
      && free_page_count_r == `PBM_FREE_RESET;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd)
    else $error("reset command did not free everything");

  property p_pop;
    @(posedge core_clk) disable iff (rst)
    (rx_pop && !rx_in) |=> rxq_cnt_r == $past(rxq_cnt_r) - 1'h1;
  endproperty
  a_pop: assert property (p_pop)
    else $error("receive queue head not dropped");

  property p_txrst;
    @(posedge core_clk) disable iff (rst)
    tx_clr |=> txq_cnt_r[$past(tx_sel_r)] == '0 &&
      ($past(used_r & ~rel_mask) & ~used_r) == '0;
  endproperty
  a_txrst: assert property (p_txrst)
    else $error("endpoint queue not emptied");

  property p_hold;
    @(posedge core_clk) disable iff (rst)
    (receive_hold_r && state_r == PBM_IDLE) |=> rx_nak_r &&
      !(state_r == PBM_ALLOCATION_DONE_IRQ && allocation_done_irq_rx_r && $past(state_r) == PBM_IDLE);
  endproperty
  a_hold: assert property (p_hold)
    else $error("receive engine not held off");

  property p_free;
    @(posedge core_clk) disable iff (rst)
    free_page_count_r == 6'($countones(~used_r));
  endproperty
  a_free: assert property (p_free)
    else $error("free page count does not match page map");
endmodule : pbm_regs

// ==== rtl/pbm_defs.svh ====
// register map, opcodes, field positions and reset values of the page manager
`ifndef PBM_DEFS_SVH
`define PBM_DEFS_SVH
`define PBM_ADDR_WINDOW 16'h6000
`define PBM_ADDR_PLOW 16'h7f50
`define PBM_ADDR_PHIGH 16'h7f51
`define PBM_ADDR_TXSEL 16'h7f52
`define PBM_ADDR_CMD 16'h7f53
`define PBM_ADDR_ARR 16'h7f54
`define PBM_ADDR_PNR 16'h7f55
`define PBM_ADDR_FREE 16'h7f56
`define PBM_OP_NOOP 3'h0
`define PBM_OP_ALLOCATION_DONE_IRQ 3'h1
`define PBM_OP_RESET 3'h2
`define PBM_OP_POP 3'h3
`define PBM_OP_POP_REL 3'h4
`define PBM_OP_REL_PKT 3'h5
`define PBM_OP_ENQ 3'h6
`define PBM_OP_TXRST 3'h7
`define PBM_MAX_COUNT 4'h9
`define PBM_BIT_RCV 7
`define PBM_BIT_STEP 6
`define PBM_BIT_READ 5
`define PBM_BIT_HOLD 7
`define PBM_FREE_RESET 6'h20
`define PBM_PAGES 32
`define PBM_PAGE_BYTES 128
`endif

// ==== rtl/pbm_pkg.sv ====
// types shared by the page manager
package pbm_pkg;
  typedef enum logic [0:0] {
    PBM_IDLE = 1'b0,
    PBM_ALLOCATION_DONE_IRQ = 1'b1
  } pbm_state_e;
  typedef logic [4:0] pbm_pkt_t;
endpackage : pbm_pkg

// ==== sim/pbm_rx_model.sv ====
// receive engine model: page requests, queue pushes and page releases
`timescale 1ns/1ps
module pbm_rx_model (
  input wire logic core_clk,
  output logic rx_allocation_done_irq_req,
  output logic [3:0] rx_allocation_done_irq_pages,
  output logic rx_push,
  output pbm_pkg::pbm_pkt_t rx_push_pkt,
  output logic rx_release,
  output pbm_pkg::pbm_pkt_t rx_release_pkt,
  input wire logic rx_grant_r,
  input wire pbm_pkg::pbm_pkt_t rx_grant_pkt_r
);
  import pbm_pkg::*;
  initial begin
    rx_allocation_done_irq_req = 1'b0;
    rx_allocation_done_irq_pages = 4'h0;
    rx_push = 1'b0;
    rx_push_pkt = 5'h00;
    rx_release = 1'b0;
    rx_release_pkt = 5'h00;
  end
  // request stays up until the grant pulse is seen or 400 cycles pass; gap makes it slow
  task automatic req(input logic [3:0] n, input int gap,
                     output pbm_pkt_t pkt, output logic ok);
    ok = 1'b0;
    pkt = 5'h00;
    repeat (gap + 1) @(negedge core_clk);
    rx_allocation_done_irq_req = 1'b1;
    rx_allocation_done_irq_pages = n;
    for (int k = 0; k < 400 && !ok; k++) begin
      @(negedge core_clk);
      ok = rx_grant_r === 1'b1;
      pkt = rx_grant_pkt_r;
    end
    rx_allocation_done_irq_req = 1'b0;
    rx_allocation_done_irq_pages = ~n;
  endtask : req
  // idle packet fields flip so a stale value is never mistaken for data
  task automatic push(input pbm_pkt_t p);
    @(negedge core_clk);
    rx_push = 1'b1;
    rx_push_pkt = p;
    @(negedge core_clk);
    rx_push = 1'b0;
    rx_push_pkt = ~p;
  endtask : push
  task automatic rel(input pbm_pkt_t p);
    @(negedge core_clk);
    rx_release = 1'b1;
    rx_release_pkt = p;
    @(negedge core_clk);
    rx_release = 1'b0;
    rx_release_pkt = ~p;
  endtask : rel
endmodule : pbm_rx_model

// ==== sim/pbm_regs_tb.sv ====
// self-checking bench for the page manager registers
`timescale 1ns/1ps
`include "pbm_defs.svh"
module pbm_regs_tb;
  import pbm_pkg::*;
  logic core_clk, rst, cpu_wr, cpu_rd, rx_allocation_done_irq_req, rx_push, rx_release;
  logic [15:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata_r;
  logic [3:0] rx_allocation_done_irq_pages, tx_ep, ep;
  logic rx_grant_r, rx_nak_r, rx_queue_empty_r, ok, rd_seen;
  logic allocation_done_irq_r, tx_pop, tx_head_valid_r;
  pbm_pkt_t rx_grant_pkt_r, rx_push_pkt, rx_release_pkt, tx_head_pkt_r, pkt;
  logic [7:0] exp_q[$], msk_q[$], b[3];
  string nam_q[$];
  int errors, check_count;
  pbm_regs pbm_regs_i (.core_clk(core_clk), .rst(rst), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata_r(cpu_rdata_r), .rx_allocation_done_irq_req(rx_allocation_done_irq_req),
    .rx_allocation_done_irq_pages(rx_allocation_done_irq_pages), .rx_grant_r(rx_grant_r),
    .rx_grant_pkt_r(rx_grant_pkt_r), .rx_push(rx_push),
    .rx_push_pkt(rx_push_pkt), .rx_release(rx_release),
    .rx_release_pkt(rx_release_pkt), .rx_nak_r(rx_nak_r),
    .rx_queue_empty_r(rx_queue_empty_r),
    .allocation_done_irq_r(allocation_done_irq_r), .tx_ep(tx_ep),
    .tx_pop(tx_pop), .tx_head_pkt_r(tx_head_pkt_r),
    .tx_head_valid_r(tx_head_valid_r));
  pbm_rx_model pbm_rx_model_i (.core_clk(core_clk),
    .rx_allocation_done_irq_req(rx_allocation_done_irq_req), .rx_allocation_done_irq_pages(rx_allocation_done_irq_pages),
    .rx_push(rx_push), .rx_push_pkt(rx_push_pkt),
    .rx_release(rx_release), .rx_release_pkt(rx_release_pkt),
    .rx_grant_r(rx_grant_r), .rx_grant_pkt_r(rx_grant_pkt_r));
  always #2 core_clk = ~core_clk;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g, input logic [7:0] m);
    check_count++;
    if ((g & m) !== (e & m)) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e & m, g & m);
    end
  endtask : chk
  task automatic flag(input string n, input logic e, input logic g);
    chk(n, {7'h00, e}, {7'h00, g}, 8'h01);
  endtask : flag
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : idle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge core_clk);
    cpu_wr = 1'b0;
    cpu_wdata = ~d;
  endtask : wr
  // expected read data is queued; the monitor compares it a cycle later
  task automatic rd(input logic [15:0] a, input logic [7:0] e,
                    input logic [7:0] m, input string n);
    @(negedge core_clk);
    exp_q.push_back(e);
    msk_q.push_back(m);
    nam_q.push_back(n);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge core_clk);
    cpu_rd = 1'b0;
  endtask : rd
  task automatic cmd(input logic [2:0] op, input logic [3:0] n);
    wr(`PBM_ADDR_CMD, {op, 1'b0, n});
  endtask : cmd
  task automatic ptr(input logic [7:0] lo, input logic [7:0] hi);
    wr(`PBM_ADDR_PLOW, lo);
    wr(`PBM_ADDR_PHIGH, hi);
    idle(2);
  endtask : ptr
  task automatic free(input logic [5:0] n, input logic h);
    rd(`PBM_ADDR_FREE, {h, 1'b0, n}, 8'hff, "free_page_count");
  endtask : free
  task automatic wait_irq();
    int k = 0;
    while (allocation_done_irq_r !== 1'b1 && k < 100) begin
      @(negedge core_clk);
      k++;
    end
    flag("allocation_done_irq_irq", 1'b1, allocation_done_irq_r);
    @(negedge core_clk);
  endtask : wait_irq
  task automatic wrap_up();
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  always @(posedge core_clk) rd_seen <= cpu_rd;
  always @(negedge core_clk) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      chk(nam_q.pop_front(), exp_q.pop_front(), cpu_rdata_r,
          msk_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    wrap_up();
  end
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    errors = 0;
    check_count = 0;
    core_clk = 1'b0;
    rst = 1'b1;
    cpu_addr = 16'h0000;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_wdata = 8'h00;
    tx_ep = 4'h0;
    tx_pop = 1'b0;
    void'($urandom(51));
    idle(4);
    rst = 1'b0;
    free(6'h20, 1'b0);
    rd(16'h7f5f, 8'h00, 8'hff, "unmapped");
    cmd(`PBM_OP_ALLOCATION_DONE_IRQ, 4'h9);
    rd(`PBM_ADDR_ARR, 8'h80, 8'h80, "failed");
    wait_irq();
    rd(`PBM_ADDR_ARR, 8'h00, 8'hff, "result");
    free(6'h16, 1'b0);
    cmd(`PBM_OP_ALLOCATION_DONE_IRQ, 4'h1);
    wait_irq();
    rd(`PBM_ADDR_ARR, 8'h0a, 8'hff, "result");
    cmd(`PBM_OP_NOOP, 4'h0);
    cmd(`PBM_OP_ALLOCATION_DONE_IRQ, 4'ha);
    rd(`PBM_ADDR_ARR, 8'h00, 8'h80, "failed");
    free(6'h14, 1'b0);
    // offsets 0x1fe..0x200 carry into the high pointer bits
    wr(`PBM_ADDR_PNR, 8'h00);
    ptr(8'hfe, 8'h41);
    foreach (b[i]) begin
      b[i] = 8'($urandom);
      wr(`PBM_ADDR_WINDOW, b[i]);
    end
    idle(60);
    ptr(8'hfe, 8'h61);
    foreach (b[i]) rd(`PBM_ADDR_WINDOW, b[i], 8'hff, "window");
    rd(`PBM_ADDR_PHIGH, 8'h62, 8'hff, "pointer_high");
    ptr(8'hfe, 8'h21);
    rd(`PBM_ADDR_WINDOW, b[0], 8'hff, "window");
    rd(`PBM_ADDR_WINDOW, b[0], 8'hff, "window");
    rd(`PBM_ADDR_PLOW, 8'hfe, 8'hff, "pointer_low");
    pbm_rx_model_i.push(5'h0a);
    wr(`PBM_ADDR_PNR, 8'h0a);
    ptr(8'h00, 8'h00);
    wr(`PBM_ADDR_WINDOW, 8'h5a);
    idle(60);
    wr(`PBM_ADDR_PNR, 8'h00);
    ptr(8'h00, 8'ha0);
    rd(`PBM_ADDR_WINDOW, 8'h5a, 8'hff, "rx_window");
    flag("rx_empty", 1'b0, rx_queue_empty_r);
    cmd(`PBM_OP_POP, 4'h0);
    idle(4);
    flag("rx_empty", 1'b1, rx_queue_empty_r);
    free(6'h14, 1'b0);
    pbm_rx_model_i.push(5'h0a);
    cmd(`PBM_OP_POP_REL, 4'h0);
    idle(4);
    flag("rx_empty", 1'b1, rx_queue_empty_r);
    free(6'h16, 1'b0);
    cmd(`PBM_OP_REL_PKT, 4'h0);
    idle(4);
    free(6'h20, 1'b0);
    ep = 4'($urandom);
    wr(`PBM_ADDR_TXSEL, {4'hf, ep});
    rd(`PBM_ADDR_TXSEL, {4'h0, ep}, 8'hff, "tx_queue_select");
    wr(`PBM_ADDR_PNR, 8'he5);
    cmd(`PBM_OP_ENQ, 4'h0);
    wr(`PBM_ADDR_PNR, 8'h06);
    cmd(`PBM_OP_ENQ, 4'h0);
    tx_ep = ep;
    idle(2);
    flag("tx_valid", 1'b1, tx_head_valid_r);
    chk("tx_head", 8'h05, {3'h0, tx_head_pkt_r}, 8'hff);
    tx_pop = 1'b1;
    idle(1);
    tx_pop = 1'b0;
    idle(2);
    chk("tx_head", 8'h06, {3'h0, tx_head_pkt_r}, 8'hff);
    tx_ep = ep + 4'h1;
    idle(2);
    flag("tx_valid", 1'b0, tx_head_valid_r);
    tx_ep = ep;
    cmd(`PBM_OP_TXRST, 4'h0);
    idle(2);
    flag("tx_valid", 1'b0, tx_head_valid_r);
    free(6'h20, 1'b0);
    wr(`PBM_ADDR_FREE, 8'hc0);
    idle(2);
    flag("rx_nak", 1'b1, rx_nak_r);
    free(6'h20, 1'b1);
    fork
      pbm_rx_model_i.req(4'h1, 3, pkt, ok);
      begin
        idle(30);
        free(6'h20, 1'b1);
        wr(`PBM_ADDR_FREE, 8'h00);
      end
    join
    flag("rx_grant", 1'b1, ok);
    chk("rx_pkt", 8'h00, {3'h0, pkt}, 8'hff);
    flag("rx_nak", 1'b0, rx_nak_r);
    free(6'h1e, 1'b0);
    repeat (3) begin
      cmd(`PBM_OP_ALLOCATION_DONE_IRQ, 4'h9);
      wait_irq();
    end
    free(6'h00, 1'b0);
    cmd(`PBM_OP_ALLOCATION_DONE_IRQ, 4'h1);
    idle(20);
    rd(`PBM_ADDR_ARR, 8'h80, 8'h80, "failed");
    pbm_rx_model_i.rel(5'h00);
    wait_irq();
    rd(`PBM_ADDR_ARR, 8'h00, 8'hff, "result");
    free(6'h00, 1'b0);
    cmd(`PBM_OP_RESET, 4'h0);
    idle(4);
    free(6'h20, 1'b0);
    flag("rx_empty", 1'b1, rx_queue_empty_r);
    idle(2);
    wrap_up();
  end
endmodule : pbm_regs_tb
